/* File: fmu_pkg.sv */
// fmu_pkg.sv: op codes, states and constants of the float math unit
// assumes one clock at 250 MHz; no figure here is a time
//
// Functional notes
// - values are IEEE single, two 16-bit halves
// - level enable reruns in each idle cycle; pulse once
// - integer to float into destination pair
// - float pair converted to integer destination
// - integer overflow: skip, keep result, error
// - add; overflow raises flag, result kept
// - subtract; overflow raises flag, result kept
// - multiply; overflow raises flag, result kept
// - divide; overflow raises flag, result kept
// - compare sets equal, greater or less flag
// - exactly one compare flag set after a compare
// - zone compare: inside, above or below flag
// - upper below lower: error, no comparison
// - square root into destination pair
// - negative root source: error, no operation
// - sine of hundredths-degree angle, to float
// - cosine of hundredths-degree angle, to float
// - angle out of range: error, skip
`default_nettype none
package fmu_pkg;
    // operation select driven by the sequencer
    typedef enum logic [3:0] {
        OP_I2F = 4'h0, OP_F2I = 4'h1, OP_ADD = 4'h2, OP_SUB = 4'h3,
        OP_MUL = 4'h4, OP_DIV = 4'h5, OP_CMP = 4'h6, OP_ZCP = 4'h7,
        OP_SQRT = 4'h8, OP_SIN = 4'h9, OP_COS = 4'hA
    } fmu_op_e;
    // sequencing states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN  = 3'b100
    } fmu_state_e;
    // float format
    localparam int FP_BIAS      = 32'h7F;  // exponent bias
    localparam int FP_EXP_INF   = 32'hFF;  // first biased exponent too large
    localparam int PK_W         = 50;      // packer magnitude width
    localparam int SCALE_W      = 12;      // packer binary scale width
    localparam logic [7:0] EXP_ONE   = 8'h7F;  // exponent of 1.0
    localparam logic [7:0] EXP_UNIT  = 8'h96;  // exponent where lsb weighs 1
    localparam logic [7:0] EXP_I32   = 8'h9E;  // 2**31, no longer fits
    localparam logic [11:0] ADD_OFS  = 12'h0AE; // unit exp plus 24 guard bits
    localparam logic [11:0] MUL_OFS  = 12'h12C; // twice the unit exponent
    localparam logic [11:0] SQ_ODD   = 12'h019; // radicand shift, odd exp
    localparam logic [11:0] SQ_EVEN  = 12'h01A; // radicand shift, even exp
    // iteration counts
    localparam logic [4:0] DIV_STEPS  = 5'h1A;  // quotient bits
    localparam logic [4:0] SQRT_STEPS = 5'h19;  // root bits
    localparam logic [4:0] CORDIC_N   = 5'h10;  // rotation steps
    // angles in hundredths of a degree
    localparam logic signed [15:0] ANGLE_LIM = 16'sh4650; // half turn
    localparam logic signed [15:0] ANGLE_QTR = 16'sh2328; // quarter turn
    localparam logic signed [19:0] CORDIC_K  = 20'sh09B75; // gain, Q16
    localparam int TRIG_FRAC = 16;              // fraction bits of x and y
    // arctangent of 2**-i in 1/256 hundredths of a degree
    localparam logic [20:0] ATAN_TAB [0:15] = '{
        21'h119400, 21'h0A6081, 21'h057BA0, 21'h02C880,
        21'h0165A2, 21'h00B2FE, 21'h005984, 21'h002CC3,
        21'h001662, 21'h000B31, 21'h000598, 21'h0002CC,
        21'h000166, 21'h0000B3, 21'h00005A, 21'h00002D
    };
endpackage : fmu_pkg
`default_nettype wire

/* File: fmu_pack_if.sv */
// fmu_pack_if.sv: link between the unit's sequencer and its float packer
// assumes both ends share one clock; the link is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface fmu_pack_if;
    import fmu_pkg::*;
    logic                      sign;   // sign of the value
    logic [PK_W-1:0]           mag;    // unsigned magnitude
    logic signed [SCALE_W-1:0] scale;  // value = mag * 2**scale
    logic [31:0]               fp;     // packed single
    logic                      ovf;    // too large for a single
    modport src (output sign, mag, scale, input fp, ovf);
    modport pk  (input sign, mag, scale, output fp, ovf);
endinterface : fmu_pack_if
`default_nettype wire

/* File: fmu_pack.sv */
// fmu_pack.sv: normalises a scaled magnitude into a single
// assumes magnitude, sign and scale are steady while the sequencer commits
`timescale 1ns/1ps
`default_nettype none
module fmu_pack
    import fmu_pkg::*;
(
    // request and packed answer
    fmu_pack_if.pk p
);
    logic [5:0]        lead;  // position of the leading one
    logic [PK_W-1:0]   norm;  // magnitude with leading one at the top
    logic signed [12:0] bexp; // biased exponent before range checks
    logic              zero;  // result is zero or underflows

    // leading-one search; the highest set bit wins
    always_comb begin
        lead = 6'h00;
        for (int i = 0; i < PK_W; i++) begin
            if (p.mag[i]) begin
                lead = 6'(i);
            end
        end
    end

    assign norm = p.mag << (6'(PK_W - 1) - lead);
    assign bexp = $signed({7'h00, lead}) + 13'(p.scale) + 13'(FP_BIAS);
    // tiny values flush to zero; subnormals are never produced
    assign zero = (p.mag == '0) || (bexp <= 13'sh0000);
    assign p.ovf = !zero && (bexp >= 13'(FP_EXP_INF));
    // fraction is truncated toward zero, which keeps the packer small
    assign p.fp = zero ? 32'h0000_0000 : {p.sign, bexp[7:0], norm[48:26]};
endmodule : fmu_pack
`default_nettype wire

/* File: fmu_top.sv */
// fmu_top.sv: single-precision execution unit for the controller sequencer
// assumes the sequencer holds op and operands steady in the trigger cycle
`timescale 1ns/1ps
`default_nettype none
module fmu_top
    import fmu_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // sequencer control
    input  wire logic        en,
    input  wire logic        pulse_mode,
    input  wire fmu_op_e     op,
    // operands, low half first in register order
    input  wire logic [31:0] first_source,
    input  wire logic [31:0] second_source,
    input  wire logic [31:0] upper_limit,
    input  wire logic [31:0] lower_limit,
    // progress
    output logic             busy,
    output logic             done,
    // result pair and flags
    output logic [31:0]      result,
    output logic             equal_or_overflow_flag,
    output logic             greater_flag,
    output logic             less_flag,
    output logic             in_zone_flag,
    output logic             above_flag,
    output logic             below_flag,
    output logic             error_flag
);
    // sequencing
    fmu_state_e         st_q, st_d;     // unit state
    logic [4:0]         cnt_q, cnt_d;   // iterations left
    logic               en_q;           // enable one cycle ago
    logic               done_q;         // commit happened last edge
    logic               trig;           // start an operation
    logic               step;           // one iteration this cycle
    logic               commit;         // write results this cycle
    logic [4:0]         load_cnt;       // iterations for this op
    // captured operands
    fmu_op_e            op_q;
    logic [31:0]        a_q, b_q, u_q, l_q;
    // iteration state
    logic [51:0]        rem_q;          // divide / root remainder
    logic [49:0]        acc_q;          // quotient or root
    logic [49:0]        rad_q;          // root radicand, two bits a step
    logic signed [19:0] x_q, y_q;       // rotation vector, Q16
    logic signed [23:0] z_q;            // angle left to rotate
    logic               neg_q;          // trig result sign flip
    // results
    logic [31:0]        res_q;
    logic               eq_q, gt_q, lt_q, zin_q, abv_q, blw_q, err_q;
    // packer link
    fmu_pack_if         pk ();

    // operand fields; zero exponent flushes the value to zero
    logic               sgn_a, sgn_b;
    logic [7:0]         ea, eb;
    logic [23:0]        ma, mb;
    logic signed [11:0] ea_s, eb_s;
    assign sgn_a = a_q[31];
    assign sgn_b = b_q[31];
    assign ea   = a_q[30:23];
    assign eb   = b_q[30:23];
    assign ma   = (ea == 8'h00) ? 24'h00_0000 : {1'b1, a_q[22:0]};
    assign mb   = (eb == 8'h00) ? 24'h00_0000 : {1'b1, b_q[22:0]};
    assign ea_s = $signed({4'h0, ea});
    assign eb_s = $signed({4'h0, eb});

    // add and subtract: align the smaller onto the larger
    logic               bsgn, a_big;
    logic [7:0]         ediff;
    logic [47:0]        m1, m2;
    logic [48:0]        add_mag;
    logic               add_sign;
    logic signed [11:0] add_scale;
    assign bsgn      = sgn_b ^ (op_q == OP_SUB);
    assign a_big     = {ea, ma} >= {eb, mb};
    assign ediff     = a_big ? ea - eb : eb - ea;
    assign m1        = {(a_big ? ma : mb), 24'h00_0000};
    assign m2        = {(a_big ? mb : ma), 24'h00_0000} >> ediff;
    assign add_sign  = a_big ? sgn_a : bsgn;
    assign add_mag   = (sgn_a == bsgn) ? {1'b0, m1} + {1'b0, m2}
                                    : {1'b0, m1 - m2};
    assign add_scale = (a_big ? ea_s : eb_s) - $signed(ADD_OFS);

    // multiply: full mantissa product
    logic [47:0]        mul_mag;
    assign mul_mag = ma * mb;

    // divide: restoring, one quotient bit per step
    logic [51:0]        mb_ext;
    logic               div_ge;
    logic               div_zero;
    assign mb_ext   = {28'h000_0000, mb};
    assign div_ge   = rem_q >= mb_ext;
    assign div_zero = (mb == 24'h00_0000);

    // square root: digit by digit, radicand shift keeps exponent even
    logic [51:0]        sq_r, sq_t;
    logic               sq_ge, sq_bad;
    logic signed [11:0] sq_scale;
    assign sq_r     = {rem_q[49:0], rad_q[49:48]};
    assign sq_t     = {acc_q[49:0], 2'b01};
    assign sq_ge    = sq_r >= sq_t;
    assign sq_bad   = sgn_a && (a_q[30:0] != 31'h0000_0000);
    assign sq_scale = (ea_s - $signed({4'h0, EXP_UNIT})
                      - $signed(ea[0] ? SQ_ODD : SQ_EVEN)) >>> 1;

    // trig: fold the angle into a quarter turn, rotate by table
    logic signed [15:0] ang, ang_red;
    logic               ang_bad, ang_fold;
    logic [3:0]         cidx;
    logic signed [19:0] xs, ys, trig_v;
    assign ang      = $signed(a_q[15:0]);
    assign ang_bad  = (ang > ANGLE_LIM) || (ang < -ANGLE_LIM);
    assign ang_fold = (ang > ANGLE_QTR) || (ang < -ANGLE_QTR);
    assign ang_red  = (ang > ANGLE_QTR) ? ang - ANGLE_LIM :
                      (ang < -ANGLE_QTR) ? ang + ANGLE_LIM : ang;
    assign cidx     = 4'(CORDIC_N - cnt_q);
    assign xs       = x_q >>> cidx;
    assign ys       = y_q >>> cidx;
    assign trig_v   = (op_q == OP_SIN) ? y_q : x_q;

    // float to integer: truncate toward zero
    logic [31:0]        f2i_mag, f2i_res;
    logic               f2i_bad;
    assign f2i_bad = ea >= EXP_I32;
    assign f2i_mag = (ea < EXP_ONE) ? 32'h0000_0000 :
                     (ea >= EXP_UNIT) ? {8'h00, ma} << (ea - EXP_UNIT) :
                     {8'h00, ma} >> (EXP_UNIT - ea);
    assign f2i_res = sgn_a ? 32'h0000_0000 - f2i_mag : f2i_mag;

    // ordering keys: -0 equals +0, negatives reversed
    function automatic logic [31:0] ord_key(input logic [31:0] v);
        if (v[30:0] == 31'h0000_0000) begin
            return 32'h8000_0000;
        end
        return v[31] ? ~v : {1'b1, v[30:0]};
    endfunction : ord_key

    logic [31:0]        ka, kb, ku, kl;
    logic               zone_bad;
    assign ka       = ord_key(a_q);
    assign kb       = ord_key(b_q);
    assign ku       = ord_key(u_q);
    assign kl       = ord_key(l_q);
    assign zone_bad = ku < kl;

    // packer source select
    always_comb begin
        pk.sign  = 1'b0;
        pk.mag   = '0;
        pk.scale = 12'sh000;
        case (op_q)
            OP_I2F: begin
                // integer value, scale zero
                pk.sign = sgn_a;
                pk.mag  = {18'h0_0000, (sgn_a ? 32'h0000_0000 - a_q : a_q)};
            end
            OP_ADD, OP_SUB: begin
                pk.sign  = add_sign;
                pk.mag   = {1'b0, add_mag};
                pk.scale = add_scale;
            end
            OP_MUL: begin
                pk.sign  = sgn_a ^ sgn_b;
                pk.mag   = {2'b00, mul_mag};
                pk.scale = ea_s + eb_s - $signed(MUL_OFS);
            end
            OP_DIV: begin
                // quotient lsb weighs 2**-(steps-1)
                pk.sign  = sgn_a ^ sgn_b;
                pk.mag   = acc_q;
                pk.scale = ea_s - eb_s - 12'(DIV_STEPS - 5'h01);
            end
            OP_SQRT: begin
                pk.mag   = acc_q;
                pk.scale = sq_scale;
            end
            OP_SIN, OP_COS: begin
                pk.sign  = trig_v[19] ^ neg_q;
                pk.mag   = {30'h0000_0000, (trig_v[19] ? -trig_v : trig_v)};
                pk.scale = -12'(TRIG_FRAC);
            end
            default: begin
                // nothing to pack
                pk.sign = 1'b0;
            end
        endcase
    end

    fmu_pack u_pack (
        .p (pk.pk)
    );

    // level form retriggers each idle cycle; pulse form needs a rising edge
    assign trig   = (st_q == ST_IDLE) && (pulse_mode ? en && !en_q : en);
    assign step   = (st_q == ST_RUN) && (cnt_q != 5'h00);
    assign commit = (st_q == ST_RUN) && (cnt_q == 5'h00);
    // error cases skip straight to commit
    assign load_cnt = (op_q == OP_DIV) ? DIV_STEPS :
                      (op_q == OP_SQRT && !sq_bad) ? SQRT_STEPS :
                      ((op_q == OP_SIN || op_q == OP_COS) && !ang_bad) ? CORDIC_N :
                      5'h00;

    // next state
    always_comb begin
        st_d  = st_q;
        cnt_d = cnt_q;
        case (st_q)
            ST_IDLE: begin
                if (trig) begin
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                st_d  = ST_RUN;
                cnt_d = load_cnt;
            end
            ST_RUN: begin
                if (cnt_q == 5'h00) begin
                    st_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 5'h01;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // state, edge history and completion pulse
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 5'h00;
            en_q   <= 1'b0;
            done_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            en_q   <= en;
            done_q <= commit;
        end
    end

    // operands are captured so the sequencer may move on
    always_ff @(posedge clk) begin
        if (srst) begin
            op_q <= OP_I2F;
            a_q  <= 32'h0000_0000;
            b_q  <= 32'h0000_0000;
            u_q  <= 32'h0000_0000;
            l_q  <= 32'h0000_0000;
        end else if (trig) begin
            op_q <= op;
            a_q  <= first_source;
            b_q  <= second_source;
            u_q  <= upper_limit;
            l_q  <= lower_limit;
        end
    end

    // iteration registers: seeded in load, stepped in run
    always_ff @(posedge clk) begin
        if (srst || st_q == ST_LOAD) begin
            rem_q <= (op_q == OP_DIV) ? {28'h000_0000, ma} : 52'h0;
            acc_q <= 50'h0;
            rad_q <= ea[0] ? {1'b0, ma, 25'h000_0000} : {ma, 26'h000_0000};
            x_q   <= CORDIC_K;
            y_q   <= 20'sh00000;
            z_q   <= {ang_red, 8'h00};
            neg_q <= ang_fold;
        end else if (step && op_q == OP_DIV) begin
            acc_q <= {acc_q[48:0], div_ge};
            rem_q <= 52'((div_ge ? rem_q - mb_ext : rem_q) << 1);
        end else if (step && op_q == OP_SQRT) begin
            acc_q <= {acc_q[48:0], sq_ge};
            rem_q <= sq_ge ? sq_r - sq_t : sq_r;
            rad_q <= {rad_q[47:0], 2'b00};
        end else if (step) begin
            // rotate toward zero residual angle
            x_q <= z_q[23] ? x_q + ys : x_q - ys;
            y_q <= z_q[23] ? y_q - xs : y_q + xs;
            z_q <= z_q[23] ? z_q + $signed({3'h0, ATAN_TAB[cidx]})
                           : z_q - $signed({3'h0, ATAN_TAB[cidx]});
        end
    end

    // commit: only the running op's own outputs change
    always_ff @(posedge clk) begin
        if (srst) begin
            res_q <= 32'h0000_0000;
            {eq_q, gt_q, lt_q} <= 3'h0;
            {zin_q, abv_q, blw_q, err_q} <= 4'h0;
        end else if (commit) begin
            case (op_q)
                OP_I2F: begin
                    res_q <= pk.fp;
                end
                OP_F2I: begin
                    err_q <= f2i_bad;
                    if (!f2i_bad) begin
                        res_q <= f2i_res;
                    end
                end
                OP_ADD, OP_SUB, OP_MUL, OP_DIV: begin
                    // divide by zero counts as overflow
                    eq_q <= pk.ovf || (op_q == OP_DIV && div_zero);
                    if (!(pk.ovf || (op_q == OP_DIV && div_zero))) begin
                        res_q <= pk.fp;
                    end
                end
                OP_CMP: begin
                    eq_q <= ka == kb;
                    gt_q <= ka > kb;
                    lt_q <= ka < kb;
                end
                OP_ZCP: begin
                    err_q <= zone_bad;
                    if (!zone_bad) begin
                        zin_q <= (ka >= kl) && (ka <= ku);
                        abv_q <= ka > ku;
                        blw_q <= ka < kl;
                    end
                end
                OP_SQRT: begin
                    err_q <= sq_bad;
                    if (!sq_bad) begin
                        res_q <= pk.fp;
                    end
                end
                OP_SIN, OP_COS: begin
                    err_q <= ang_bad;
                    if (!ang_bad) begin
                        res_q <= pk.fp;
                    end
                end
                default: begin
                    err_q <= err_q;
                end
            endcase
        end
    end

    // outputs
    assign busy                   = st_q != ST_IDLE;
    assign done                   = done_q;
    assign result                 = res_q;
    assign equal_or_overflow_flag = eq_q;
    assign greater_flag           = gt_q;
    assign less_flag              = lt_q;
    assign in_zone_flag           = zin_q;
    assign above_flag             = abv_q;
    assign below_flag             = blw_q;
    assign error_flag             = err_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_div_go;
        st_q == ST_LOAD && op_q == OP_DIV;
    endsequence
    sequence s_sqrt_neg;
        st_q == ST_LOAD && op_q == OP_SQRT && sq_bad;
    endsequence

    a_pulse_once: assert property (!busy && pulse_mode && en_q |=> !busy)
        else $error("pulse enable restarted without a rising edge");
    a_level_run: assert property (st_q == ST_IDLE && !pulse_mode && en |=> st_q == ST_LOAD)
        else $error("level enable did not start an operation");
    a_f2i_range: assert property (commit && op_q == OP_F2I && f2i_bad
        |=> err_q && $stable(res_q))
        else $error("out of range conversion changed the result");
    a_ovf_hold: assert property (done_q && eq_q &&
        op_q inside {OP_ADD, OP_SUB, OP_MUL, OP_DIV} |-> $stable(res_q))
        else $error("overflow changed the result");
    a_div_time: assert property (s_div_go |-> busy[*8] ##21 done_q)
        else $error("divide did not finish on time");
    a_cmp_single: assert property (done && op_q == OP_CMP |-> $onehot({eq_q, gt_q, lt_q}))
        else $error("compare flags not exclusive");
    a_zone_onehot: assert property (done_q && op_q == OP_ZCP && !err_q
        |-> $onehot({zin_q, abv_q, blw_q}))
        else $error("zone flags not exclusive");
    a_zone_limit: assert property (commit && op_q == OP_ZCP && zone_bad
        |=> err_q && $stable({zin_q, abv_q, blw_q}))
        else $error("bad limits still compared");
    a_sqrt_neg: assert property (s_sqrt_neg |-> ##2 done_q && err_q && $stable(res_q))
        else $error("negative root not refused");
    a_angle_err: assert property (st_q == ST_LOAD && ang_bad &&
        op_q inside {OP_SIN, OP_COS} |-> ##2 done_q && err_q && $stable(res_q))
        else $error("bad angle not refused");
    a_hold_res: assert property (!done_q |-> $stable(res_q))
        else $error("result moved outside a commit");
endmodule : fmu_top
`default_nettype wire

/* File: fmu_seq_model.sv */
// fmu_seq_model.sv: behavioural instruction sequencer feeding the unit
// assumes the unit answers each trigger with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module fmu_seq_model
    import fmu_pkg::*;
(
    // clock and answer
    input  wire logic        clk,
    input  wire logic        done,
    // request
    output var logic         en,
    output var logic         pulse_mode,
    output var fmu_op_e      op,
    output var logic [31:0]  first_source,
    output var logic [31:0]  second_source,
    output var logic [31:0]  upper_limit,
    output var logic [31:0]  lower_limit
);
    // idle values from time zero
    initial begin
        {en, pulse_mode, first_source, second_source, upper_limit, lower_limit} = '0;
        op = OP_I2F;
    end
    // one-cycle enable gives exactly one trigger in either mode
    task automatic issue(input fmu_op_e o, input logic [31:0] a, b, u, l, output bit ok);
        @(negedge clk);
        op = o;
        {first_source, second_source, upper_limit, lower_limit} = {a, b, u, l};
        en = 1'b1;
        @(negedge clk);
        en = 1'b0;
        // released operands flip so a late capture shows up
        {first_source, second_source, upper_limit, lower_limit} = ~{a, b, u, l};
        ok = 1'b0;
        for (int n = 0; n < 40 && !ok; n++) begin
            @(negedge clk);
            ok = (done === 1'b1);
        end
    endtask : issue
    // enable held high for ten cycles, done pulses counted
    task automatic hold(input logic pm, output int cnt);
        @(negedge clk);
        op = OP_ADD;
        {pulse_mode, en, cnt} = {pm, 1'b1, 32'h0};
        repeat (10) begin
            @(negedge clk);
            cnt += int'(done === 1'b1);
        end
        en = 1'b0;
        repeat (6) @(negedge clk);
        pulse_mode = 1'b0;
    endtask : hold
endmodule : fmu_seq_model
`default_nettype wire

/* File: float_math_unit_tb.sv */
// float_math_unit_tb.sv: self-checking bench for the float math unit
// assumes the sequencer model drives every request at falling edges
`timescale 1ns/1ps
`default_nettype none
module float_math_unit_tb;
    import fmu_pkg::*;
    logic        clk, srst, en, pm, busy, done;  // clock, reset, control
    fmu_op_e     op;                             // operation select
    logic [31:0] fa, fb, ul, ll, result;         // operands and result
    logic        eq, gt, lt, zin, abv, blw, err; // flags
    int          n_mismatch, samples_checked, cnt;
    int          cyc = 0;                        // timeout counter
    wire logic [6:0] fl = {eq, gt, lt, zin, abv, blw, err};
    fmu_top dut_u (.clk(clk), .srst(srst), .en(en), .pulse_mode(pm), .op(op),
        .first_source(fa), .second_source(fb), .upper_limit(ul), .lower_limit(ll),
        .busy(busy), .done(done), .result(result), .equal_or_overflow_flag(eq),
        .greater_flag(gt), .less_flag(lt), .in_zone_flag(zin), .above_flag(abv),
        .below_flag(blw), .error_flag(err));
    fmu_seq_model seq_u (.clk(clk), .done(done), .en(en), .pulse_mode(pm), .op(op),
        .first_source(fa), .second_source(fb), .upper_limit(ul), .lower_limit(ll));
    // closing report, reached from the sequence or the timeout
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // value compare; tol counts last-place steps, trig is only approximate
    task automatic cmp(input logic [31:0] g, e, input int tol);
        samples_checked++;
        if ($isunknown(g) || (tol == 0 && g !== e) || (g > e ? g - e : e - g) > tol) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // one operation, then result and masked flags; rt below zero skips the result
    task automatic tc(input fmu_op_e o, input logic [31:0] a, b, input int rt,
                      input logic [31:0] r, input logic [6:0] m, f,
                      input logic [31:0] u = 32'h0, l = 32'h0);
        bit ok;
        seq_u.issue(o, a, b, u, l, ok);
        cmp({31'h0, ok}, 32'h1, 0);
        if (rt >= 0) cmp(result, r, rt);
        cmp({24'h0, busy, fl & m}, {25'h0, f}, 0);
        $display("test %s done", o.name());
    endtask : tc
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        srst = 1'b1;
        n_mismatch = 0;
        samples_checked = 0;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        cmp(result, 32'h0, 0);
        cmp({23'h0, busy, done, fl}, 32'h0, 0);
        tc(OP_I2F, 32'hFFFFFF9C, 32'h0, 0, 32'hC2C80000, 7'h00, 7'h00);
        tc(OP_F2I, 32'h42F6E666, 32'h0, 0, 32'h0000007B, 7'h01, 7'h00);
        tc(OP_F2I, 32'h4F000000, 32'h0, 0, 32'h0000007B, 7'h01, 7'h01);
        tc(OP_ADD, 32'h3FC00000, 32'h40200000, 0, 32'h40800000, 7'h40, 7'h00);
        tc(OP_ADD, 32'h7F7FFFFF, 32'h7F7FFFFF, 0, 32'h40800000, 7'h40, 7'h40);
        tc(OP_SUB, 32'h3FC00000, 32'h40200000, 0, 32'hBF800000, 7'h40, 7'h00);
        tc(OP_SUB, 32'hFF7FFFFF, 32'h7F7FFFFF, 0, 32'hBF800000, 7'h40, 7'h40);
        tc(OP_MUL, 32'h3FC00000, 32'h40200000, 0, 32'h40700000, 7'h40, 7'h00);
        tc(OP_MUL, 32'h7F000000, 32'h7F000000, 0, 32'h40700000, 7'h40, 7'h40);
        tc(OP_DIV, 32'h40400000, 32'h40000000, 0, 32'h3FC00000, 7'h40, 7'h00);
        tc(OP_DIV, 32'h40400000, 32'h00000000, 0, 32'h3FC00000, 7'h40, 7'h40);
        tc(OP_CMP, 32'h43483333, 32'h4348199A, -1, 32'h0, 7'h70, 7'h20);
        tc(OP_CMP, 32'h43483333, 32'h43483333, -1, 32'h0, 7'h70, 7'h40);
        tc(OP_CMP, 32'h4348199A, 32'h43483333, -1, 32'h0, 7'h70, 7'h10);
        tc(OP_ADD, 32'h3FC00000, 32'h40200000, 0, 32'h40800000, 7'h7F, 7'h11);
        tc(OP_ZCP, 32'h40000000, 0, -1, 0, 7'h0F, 7'h08, 32'h40400000, 32'h3F800000);
        tc(OP_ZCP, 32'h3F800000, 0, -1, 0, 7'h0F, 7'h08, 32'h40400000, 32'h3F800000);
        tc(OP_ZCP, 32'h40800000, 0, -1, 0, 7'h0F, 7'h04, 32'h40400000, 32'h3F800000);
        tc(OP_ZCP, 32'h3F000000, 0, -1, 0, 7'h0F, 7'h02, 32'h40400000, 32'h3F800000);
        tc(OP_ZCP, 32'h40000000, 0, -1, 0, 7'h0F, 7'h03, 32'h3F800000, 32'h40400000);
        tc(OP_SQRT, 32'h40800000, 32'h0, 0, 32'h40000000, 7'h01, 7'h00);
        tc(OP_SQRT, 32'hC0800000, 32'h0, 0, 32'h40000000, 7'h01, 7'h01);
        tc(OP_SIN, 32'h00000BB8, 32'h0, 4096, 32'h3F000000, 7'h01, 7'h00);
        tc(OP_COS, 32'h00001770, 32'h0, 4096, 32'h3F000000, 7'h01, 7'h00);
        tc(OP_COS, 32'h0000B9B0, 32'h0, 4096, 32'hBF800000, 7'h01, 7'h00);
        tc(OP_SIN, 32'h00004651, 32'h0, 4096, 32'hBF800000, 7'h01, 7'h01);
        tc(OP_COS, 32'h0000B9AF, 32'h0, 4096, 32'hBF800000, 7'h01, 7'h01);
        seq_u.hold(1'b0, cnt);
        cmp(cnt, 32'd3, 0);
        seq_u.hold(1'b1, cnt);
        cmp(cnt, 32'd1, 0);
        $display("test enable modes done");
        print_verdict();
    end
endmodule : float_math_unit_tb
`default_nettype wire
